// ===== hw/dcdcwd_pkg.sv
// Purpose: constants and types for the dc drive control word decoder
// Assumes: 100 MHz clk, classic Wishbone slave with 32-bit data
// Notes: pilot and speed words are held as decimal digits, one nibble per digit; pickup and line sync are binary
package dcdcwd_pkg;
    // register byte offsets
    localparam logic [7:0] REG_PICKUP = 8'h00;
    localparam logic [7:0] REG_LINESYNC = 8'h04;
    localparam logic [7:0] REG_PILOT = 8'h08;
    localparam logic [7:0] REG_SPEED = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // reset values and ranges
    localparam logic [6:0] PICKUP_RESET = 7'h00;
    localparam logic [6:0] PICKUP_MAX = 7'h64;
    localparam logic [7:0] SYNC_RESET = 8'hC8;
    localparam logic [7:0] SYNC_MAX = 8'hC8;
    localparam logic [7:0] SYNC_AVG_MAX = 8'h09;
    localparam logic [11:0] PILOT_RESET = 12'h001;
    localparam logic [3:0] PILOT_ONES_MAX = 4'h2;
    localparam logic [3:0] PILOT_TENS_MAX = 4'h1;
    localparam logic [3:0] PILOT_HUND_MAX = 4'h3;
    localparam logic [15:0] SPEED_RESET = 16'h0011;
    localparam logic [3:0] SPEED_ONES_MAX = 4'h3;
    localparam logic [3:0] SPEED_HIGH_MAX = 4'h1;
    localparam logic [7:0] PILOT_PARK_ANGLE = 8'hA5;
    // timing
    localparam int CLK_FREQ_HZ = 100000000;
    localparam int PICKUP_STEP_MS = 10;
    localparam int PICKUP_STEP_CYCLES = CLK_FREQ_HZ / 1000 * PICKUP_STEP_MS;
    // status bit positions
    localparam int ST_REJECT = 0;
    localparam int ST_WAITING = 1;
    localparam int ST_FIRING = 2;
    localparam int ST_SYNC_PENDING = 3;

    typedef enum logic [1:0] {SYNC_DIRECT, SYNC_AVG, SYNC_FILT, SYNC_FILT_EXTRA} dcdcwd_syncm_t;
    typedef enum logic [1:0] {EMF_LAG, EMF_NONE, EMF_MEAN2, EMF_MEAN3} dcdcwd_emff_t;
    typedef enum logic [1:0] {ST_IDLE, ST_TIMING, ST_HOLD, ST_DONE} dcdcwd_fsm_t;

    typedef struct packed {
        dcdcwd_syncm_t mode;
        logic [3:0] avgPeriods;
        logic [7:0] filterTcMs;
    } dcdcwd_sync_t;

    typedef struct packed {
        logic enable;
        logic zeroEmf;
        logic emfFromCalc;
        dcdcwd_emff_t emfFilter;
    } dcdcwd_pilot_t;

    typedef struct packed {
        logic integralEnable;
        logic haltTorqueOrCurrent;
        logic haltTorqueOnly;
        logic haltAtMaxOnly;
        logic propEnable;
        logic setpointNegate;
        logic feedbackNegate;
    } dcdcwd_speed_t;
endpackage

// ===== hw/dcdcwd_top.sv
// Purpose: decodes drive settings and runs the contactor pickup wait
// Assumes: all inputs synchronous to clk, sys_rst synchronous active high
// Notes: one Wishbone cycle answers with ack one cycle after the request
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
module dcdcwd_top #(
    parameter int STEP_CYCLES = dcdcwd_pkg::PICKUP_STEP_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // drive state
    input wire logic driveOn,
    input wire logic pulseEnableState,
    input wire logic lineContactorState,
    input wire logic powerVoltagePresent,
    output logic contactorWaitState,
    output logic firingEnable,
    // decoded settings
    output dcdcwd_pkg::dcdcwd_sync_t syncCfg,
    output dcdcwd_pkg::dcdcwd_pilot_t pilotCfg,
    output dcdcwd_pkg::dcdcwd_speed_t speedCfg,
    // data paths
    input wire logic [7:0] pilotAngleIn,
    input wire logic torqueReversal,
    input wire logic signed [15:0] setpointIn,
    input wire logic signed [15:0] actualIn,
    output logic [7:0] pilotAngleOut,
    output logic integratorLoad,
    output logic signed [15:0] setpointOut,
    output logic signed [15:0] actualOut
);
    import dcdcwd_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] rdData;
        dcdcwd_fsm_t fsm;
        logic [19:0] tickCnt;
        logic [6:0] waitCnt;
        logic [6:0] pickup;
        logic [7:0] syncReg;
        logic [7:0] syncEff;
        logic [11:0] pilot;
        logic [15:0] speed;
        logic reject;
        logic [7:0] angle;
        logic load;
        logic signed [15:0] setp;
        logic signed [15:0] act;
    } dcdcwd_state_t;

    dcdcwd_state_t state_q;
    dcdcwd_state_t state_d;

    logic busReq;
    logic wrStb;
    logic [31:0] wrVal;
    logic waitExpired;
    logic [19:0] stepLast;

    // sync method class: 0 direct, 1 averaging, 2 filtering
    function automatic logic [1:0] syncClass(input logic [7:0] v);
        if (v == 8'h00) begin
            syncClass = 2'h0;
        end else if (v <= SYNC_AVG_MAX) begin
            syncClass = 2'h1;
        end else begin
            syncClass = 2'h2;
        end
    endfunction

    // merge the selected byte lanes of a write into the old value
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
        laneMerge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                laneMerge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    assign busReq = wb_cyc_i && wb_stb_i && !state_q.ack;
    assign wrStb = busReq && wb_we_i;
    assign stepLast = 20'(STEP_CYCLES - 1);
    assign waitExpired = (state_q.waitCnt >= state_q.pickup);

    // next state
    always_comb begin
        state_d = state_q;
        state_d.ack = busReq;
        state_d.load = 1'b0;
        wrVal = 32'h0000_0000;

        // register writes with range checks
        if (wrStb) begin
            unique case (wb_adr_i)
                REG_PICKUP: begin
                    wrVal = laneMerge({25'h0, state_q.pickup}, wb_dat_i, wb_sel_i);
                    if (wrVal <= {25'h0, PICKUP_MAX}) begin
                        state_d.pickup = wrVal[6:0];
                    end
                end
                REG_LINESYNC: begin
                    wrVal = laneMerge({24'h0, state_q.syncReg}, wb_dat_i, wb_sel_i);
                    if (wrVal <= {24'h0, SYNC_MAX}) begin
                        state_d.syncReg = wrVal[7:0];
                    end
                end
                REG_PILOT: begin
                    wrVal = laneMerge({20'h0, state_q.pilot}, wb_dat_i, wb_sel_i);
                    if (driveOn) begin
                        state_d.reject = 1'b1;
                    end else if (wrVal[31:12] == 20'h0 && wrVal[3:0] <= PILOT_ONES_MAX
                                 && wrVal[7:4] <= PILOT_TENS_MAX
                                 && wrVal[11:8] <= PILOT_HUND_MAX) begin
                        state_d.pilot = wrVal[11:0];
                    end
                end
                REG_SPEED: begin
                    wrVal = laneMerge({16'h0, state_q.speed}, wb_dat_i, wb_sel_i);
                    if (driveOn) begin
                        state_d.reject = 1'b1;
                    end else if (wrVal[31:16] == 16'h0 && wrVal[3:0] <= SPEED_ONES_MAX
                                 && wrVal[7:4] <= SPEED_HIGH_MAX
                                 && wrVal[11:8] <= SPEED_HIGH_MAX
                                 && wrVal[15:12] <= SPEED_HIGH_MAX) begin
                        state_d.speed = wrVal[15:0];
                    end
                end
                REG_STATUS: begin
                    // write one clears; reject is set only by pilot or speed writes, so none can arrive in the same cycle
                    if (wb_sel_i[0] && wb_dat_i[ST_REJECT]) begin
                        state_d.reject = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // read data, unmapped addresses read zero
        if (busReq && !wb_we_i) begin
            unique case (wb_adr_i)
                REG_PICKUP: state_d.rdData = {25'h0, state_q.pickup};
                REG_LINESYNC: state_d.rdData = {24'h0, state_q.syncReg};
                REG_PILOT: state_d.rdData = {20'h0, state_q.pilot};
                REG_SPEED: state_d.rdData = {16'h0, state_q.speed};
                REG_STATUS: state_d.rdData = {28'h0, state_q.syncReg != state_q.syncEff,
                                              state_q.fsm == ST_DONE,
                                              state_q.fsm == ST_HOLD, state_q.reject};
                default: state_d.rdData = 32'h0000_0000;
            endcase
        end

        // method change is applied now or deferred until the power circuit is dead
        if (!powerVoltagePresent || (syncClass(state_q.syncReg) == syncClass(state_q.syncEff)
                                     && syncClass(state_q.syncEff) != 2'h1)) begin
            state_d.syncEff = state_q.syncReg;
        end

        // pickup wait timer in 10 ms steps
        if (state_q.fsm == ST_TIMING || state_q.fsm == ST_HOLD) begin
            if (state_q.tickCnt == stepLast) begin
                state_d.tickCnt = 20'h0_0000;
                if (!waitExpired) begin
                    state_d.waitCnt = state_q.waitCnt + 7'h01;
                end
            end else begin
                state_d.tickCnt = state_q.tickCnt + 20'h0_0001;
            end
        end

        // start sequence
        unique case (state_q.fsm)
            ST_IDLE: begin
                state_d.tickCnt = 20'h0_0000;
                state_d.waitCnt = 7'h00;
                if (driveOn && pulseEnableState) begin
                    state_d.fsm = ST_TIMING;
                end
            end
            ST_TIMING: begin
                if (!pulseEnableState && !lineContactorState) begin
                    state_d.fsm = waitExpired ? ST_DONE : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (waitExpired) begin
                    state_d.fsm = ST_DONE;
                end
            end
            ST_DONE: begin
            end
        endcase
        if (!driveOn) begin
            state_d.fsm = ST_IDLE;
        end

        // data paths
        state_d.angle = pilotCfg.enable ? pilotAngleIn : PILOT_PARK_ANGLE;
        state_d.load = pilotCfg.zeroEmf && torqueReversal;
        state_d.setp = speedCfg.setpointNegate ? 16'(-setpointIn) : setpointIn;
        state_d.act = speedCfg.feedbackNegate ? 16'(-actualIn) : actualIn;
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= '0;
            state_q.fsm <= ST_IDLE;
            state_q.pickup <= PICKUP_RESET;
            state_q.syncReg <= SYNC_RESET;
            state_q.syncEff <= SYNC_RESET;
            state_q.pilot <= PILOT_RESET;
            state_q.speed <= SPEED_RESET;
            state_q.angle <= PILOT_PARK_ANGLE;
        end else begin
            state_q <= state_d;
        end
    end

    // line sync decode from the effective setting
    always_comb begin
        syncCfg.avgPeriods = 4'h0;
        syncCfg.filterTcMs = 8'h00;
        unique case (syncClass(state_q.syncEff))
            2'h0: syncCfg.mode = SYNC_DIRECT;
            2'h1: begin
                syncCfg.mode = SYNC_AVG;
                syncCfg.avgPeriods = state_q.syncEff[3:0];
            end
            default: begin
                syncCfg.filterTcMs = state_q.syncEff;
                syncCfg.mode = state_q.syncEff[0] ? SYNC_FILT_EXTRA : SYNC_FILT;
            end
        endcase
    end

    // pilot and speed word decode
    always_comb begin
        pilotCfg.enable = state_q.pilot[3:0] != 4'h0;
        pilotCfg.zeroEmf = state_q.pilot[3:0] == PILOT_ONES_MAX;
        pilotCfg.emfFromCalc = state_q.pilot[4];
        pilotCfg.emfFilter = dcdcwd_emff_t'(state_q.pilot[9:8]);
        speedCfg.integralEnable = state_q.speed[3:0] != 4'h0;
        speedCfg.haltTorqueOrCurrent = state_q.speed[3:0] == 4'h1;
        speedCfg.haltTorqueOnly = state_q.speed[3:0] == 4'h2;
        speedCfg.haltAtMaxOnly = state_q.speed[3:0] == SPEED_ONES_MAX;
        speedCfg.propEnable = state_q.speed[4];
        speedCfg.setpointNegate = state_q.speed[8];
        speedCfg.feedbackNegate = state_q.speed[12];
    end

    // outputs
    assign wb_ack_o = state_q.ack;
    assign wb_dat_o = state_q.rdData;
    assign contactorWaitState = state_q.fsm == ST_HOLD;
    assign firingEnable = state_q.fsm == ST_DONE;
    assign pilotAngleOut = state_q.angle;
    assign integratorLoad = state_q.load;
    assign setpointOut = state_q.setp;
    assign actualOut = state_q.act;

    // checks
    property p_timerStart;
        @(posedge clk) disable iff (sys_rst)
        state_q.fsm == ST_IDLE && driveOn && pulseEnableState |=> state_q.fsm == ST_TIMING;
    endproperty
    a_timerStart: assert property (p_timerStart) else $error("wait did not start");

    property p_holdOnLeave;
        @(posedge clk) disable iff (sys_rst)
        state_q.fsm == ST_TIMING && driveOn && !pulseEnableState && !lineContactorState
            && !waitExpired |=> contactorWaitState && !firingEnable;
    endproperty
    a_holdOnLeave: assert property (p_holdOnLeave) else $error("no contactor wait");

    property p_firingAfterWait;
        @(posedge clk) disable iff (sys_rst)
        $rose(firingEnable) |-> $past(waitExpired) && $past(driveOn);
    endproperty
    a_firingAfterWait: assert property (p_firingAfterWait) else $error("early firing");

    property p_pickupRange;
        @(posedge clk) disable iff (sys_rst)
        state_q.pickup <= PICKUP_MAX && state_q.syncReg <= SYNC_MAX;
    endproperty
    a_pickupRange: assert property (p_pickupRange) else $error("setting out of range");

    property p_syncDecode;
        @(posedge clk) disable iff (sys_rst)
        (syncCfg.mode == SYNC_DIRECT) == (state_q.syncEff == 8'h00)
            && (syncCfg.mode == SYNC_AVG) == (state_q.syncEff != 8'h00
                                              && state_q.syncEff <= SYNC_AVG_MAX);
    endproperty
    a_syncDecode: assert property (p_syncDecode) else $error("bad sync mode");

    property p_filterOdd;
        @(posedge clk) disable iff (sys_rst)
        state_q.syncEff > SYNC_AVG_MAX |-> syncCfg.filterTcMs == state_q.syncEff
            && (syncCfg.mode == SYNC_FILT_EXTRA) == state_q.syncEff[0];
    endproperty
    a_filterOdd: assert property (p_filterOdd) else $error("bad filter decode");

    property p_syncDeferred;
        @(posedge clk) disable iff (sys_rst)
        $past(powerVoltagePresent) && state_q.syncEff != $past(state_q.syncEff)
            |-> syncClass(state_q.syncEff) == syncClass($past(state_q.syncEff))
                && syncClass(state_q.syncEff) != 2'h1;
    endproperty
    a_syncDeferred: assert property (p_syncDeferred) else $error("sync change live");

    property p_parkAngle;
        @(posedge clk) disable iff (sys_rst)
        !pilotCfg.enable && $stable(state_q.pilot) |=> pilotAngleOut == PILOT_PARK_ANGLE;
    endproperty
    a_parkAngle: assert property (p_parkAngle) else $error("pilot not parked");

    property p_setpointSign;
        @(posedge clk) disable iff (sys_rst)
        speedCfg.setpointNegate |=> setpointOut == 16'(-$past(setpointIn));
    endproperty
    a_setpointSign: assert property (p_setpointSign) else $error("setpoint sign wrong");

    property p_offlineReject;
        @(posedge clk) disable iff (sys_rst)
        wrStb && driveOn && (wb_adr_i == REG_PILOT || wb_adr_i == REG_SPEED)
            |=> $stable(state_q.pilot) && $stable(state_q.speed) && state_q.reject;
    endproperty
    a_offlineReject: assert property (p_offlineReject) else $error("online write taken");
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the drive control word decoder
// Assumes: classic Wishbone slave acking one cycle after the taking edge
// Notes: STEP_CYCLES is cut to 4 so one 10 ms pickup step lasts 4 clocks
`timescale 1ns/1ps
module tb_top;
    import dcdcwd_pkg::*;
    localparam int STEP = 4;
    logic clk, sys_rst, wbCyc, wbStb, wbWe, wbAck;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR;
    logic driveOn, pulseEn, lineCont, powerOn, waitSt, fireEn, torqueRev, intLoad;
    dcdcwd_sync_t syncCfg;
    dcdcwd_pilot_t pilotCfg;
    dcdcwd_speed_t speedCfg;
    logic [7:0] angleIn, angleOut;
    logic signed [15:0] spIn, actIn, spOut, actOut;
    int miscompares = 0;
    int checkCount = 0;
    int cycles = 0;

    // design under test with a short pickup step
    dcdcwd_top #(.STEP_CYCLES(STEP)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .driveOn(driveOn), .pulseEnableState(pulseEn),
        .lineContactorState(lineCont), .powerVoltagePresent(powerOn),
        .contactorWaitState(waitSt), .firingEnable(fireEn), .syncCfg(syncCfg),
        .pilotCfg(pilotCfg), .speedCfg(speedCfg), .pilotAngleIn(angleIn),
        .torqueReversal(torqueRev), .setpointIn(spIn), .actualIn(actIn),
        .pilotAngleOut(angleOut), .integratorLoad(intLoad), .setpointOut(spOut),
        .actualOut(actOut)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // closing report, the only place the run ends
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("Error timeout expected end seen %0d cycles", cycles);
            wrapUp();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one classic cycle: hold until ack is sampled high, then release
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= 4'hF;
        wbDatW <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            $display("Error wb ack expected 1 seen %b", wbAck);
        end
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
        cyc(2);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(what, exp, q);
    endtask

    // sync setting table: value and mode; periods and time constant are checked against the value
    logic [7:0] syV[6] = '{8'h00, 8'h01, 8'h09, 8'h0A, 8'h0B, 8'hC8};
    logic [1:0] syM[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2};

    // main sequence
    initial begin
        sys_rst = 1'b1;
        {wbCyc, wbStb, wbWe, driveOn, pulseEn, lineCont, powerOn, torqueRev} = '0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatW = 32'h0;
        angleIn = 8'h3C;
        spIn = 16'sh1234;
        actIn = -16'sd5;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values
        rd("pickup rst", REG_PICKUP, 32'h0);
        rd("sync rst", REG_LINESYNC, 32'hC8);
        rd("pilot rst", REG_PILOT, 32'h001);
        rd("speed rst", REG_SPEED, 32'h0011);
        chk("pilot cfg rst", 32'h10, {27'h0, pilotCfg});
        chk("speed cfg rst", 32'h64, {25'h0, speedCfg});
        chk("angle pass", 32'h3C, {24'h0, angleOut});
        rd("unmapped", 8'h20, 32'h0);
        $display("test reset done");
        // sync decode table with power removed
        for (int i = 0; i < 6; i++) begin
            wr(REG_LINESYNC, {24'h0, syV[i]});
            chk("sync mode", {30'h0, syM[i]}, {30'h0, syncCfg.mode});
            if (syM[i] == 2'h1) chk("avg n", {24'h0, syV[i]}, {28'h0, syncCfg.avgPeriods});
            if (syM[i] >= 2'h2) chk("tc", {24'h0, syV[i]}, {24'h0, syncCfg.filterTcMs});
        end
        wr(REG_LINESYNC, 32'hC9);
        rd("sync range", REG_LINESYNC, 32'hC8);
        // method change held while power voltage present, drive running
        powerOn <= 1'b1;
        driveOn <= 1'b1;
        wr(REG_LINESYNC, 32'h32);
        chk("filter online", 32'h32, {24'h0, syncCfg.filterTcMs});
        wr(REG_LINESYNC, 32'h05);
        chk("held mode", 32'h2, {30'h0, syncCfg.mode});
        rd("pending", REG_STATUS, 32'h8);
        @(posedge clk);
        powerOn <= 1'b0;
        cyc(3);
        chk("late mode", 32'h1, {30'h0, syncCfg.mode});
        chk("late n", 32'h5, {28'h0, syncCfg.avgPeriods});
        $display("test sync done");
        // offline-only words refused while running
        wr(REG_PILOT, 32'h111);
        rd("pilot kept", REG_PILOT, 32'h001);
        wr(REG_SPEED, 32'h0000);
        rd("speed kept", REG_SPEED, 32'h0011);
        rd("reject flag", REG_STATUS, 32'h1);
        wr(REG_STATUS, 32'h1);
        rd("reject clr", REG_STATUS, 32'h0);
        @(posedge clk);
        driveOn <= 1'b0;
        $display("test reject done");
        // pilot word digits
        wr(REG_PILOT, 32'h000);
        chk("park angle", 32'hA5, {24'h0, angleOut});
        chk("pilot off", 32'h0, {31'h0, pilotCfg.enable});
        for (int h = 0; h < 4; h++) begin
            wr(REG_PILOT, {20'h0, h[3:0], 8'h01});
            chk("emf filter", h, {30'h0, pilotCfg.emfFilter});
            chk("emf meas", 32'h0, {31'h0, pilotCfg.emfFromCalc});
        end
        wr(REG_PILOT, 32'h312);
        chk("emf calc", 32'h1, {31'h0, pilotCfg.emfFromCalc});
        chk("zero emf", 32'h1, {31'h0, pilotCfg.zeroEmf});
        @(posedge clk);
        torqueRev <= 1'b1;
        @(posedge clk);
        torqueRev <= 1'b0;
        @(posedge clk);
        chk("int load", 32'h1, {31'h0, intLoad});
        wr(REG_PILOT, 32'h313);
        rd("pilot range", REG_PILOT, 32'h312);
        // advised pairing of pilot word and nine-period averaging
        wr(REG_PILOT, 32'h211);
        wr(REG_LINESYNC, 32'h09);
        chk("advised pilot", 32'h16, {27'h0, pilotCfg});
        chk("advised sync", 32'h9, {28'h0, syncCfg.avgPeriods});
        $display("test pilot done");
        // speed word digits
        for (int k = 0; k < 4; k++) begin
            wr(REG_SPEED, 32'h1110 + k);
            chk("speed cfg", {25'h0, k != 0, k == 1, k == 2, k == 3, 3'b111},
                {25'h0, speedCfg});
        end
        chk("sp neg", 32'h0000EDCC, {16'h0, spOut});
        chk("act neg", 32'h00000005, {16'h0, actOut});
        wr(REG_SPEED, 32'h0001);
        chk("prop off", 32'h0, {31'h0, speedCfg.propEnable});
        chk("sp plain", 32'h1234, {16'h0, spOut});
        chk("act plain", 32'hFFFB, {16'h0, actOut});
        wr(REG_SPEED, 32'h1114);
        rd("speed range", REG_SPEED, 32'h0001);
        $display("test speed done");
        // start with a 30 ms pickup wait, set while running
        @(posedge clk);
        driveOn <= 1'b1;
        wr(REG_PICKUP, 32'h3);
        wr(REG_PICKUP, 32'h65);
        rd("pickup", REG_PICKUP, 32'h3);
        @(posedge clk);
        pulseEn <= 1'b1;
        cyc(2);
        pulseEn <= 1'b0;
        lineCont <= 1'b1;
        cyc(2);
        chk("timing held", 32'h0, {31'h0, waitSt});
        lineCont <= 1'b0;
        cyc(2);
        chk("wait state", 32'h1, {31'h0, waitSt});
        chk("no fire", 32'h0, {31'h0, fireEn});
        rd("status wait", REG_STATUS, 32'h2);
        begin
            int n;
            n = 9;
            while (fireEn !== 1'b1 && n < 40) begin
                @(posedge clk);
                n++;
            end
            chk("wait length", 32'h1, {31'h0, n >= 3 * STEP - 1 && n <= 3 * STEP + 4});
        end
        rd("status fire", REG_STATUS, 32'h4);
        @(posedge clk);
        driveOn <= 1'b0;
        cyc(3);
        chk("fire off", 32'h0, {31'h0, fireEn});
        // zero wait fires straight on leaving both states
        wr(REG_PICKUP, 32'h0);
        @(posedge clk);
        driveOn <= 1'b1;
        pulseEn <= 1'b1;
        cyc(2);
        pulseEn <= 1'b0;
        cyc(3);
        chk("fire now", 32'h1, {31'h0, fireEn});
        chk("no wait", 32'h0, {31'h0, waitSt});
        driveOn <= 1'b0;
        $display("test start done");
        wrapUp();
    end
endmodule
